// file: include/fsr_pkg.sv
// Constants and types for the flash suspend, failure and read-latency status block.
package fsr_pkg;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] READ_SECOND_STATUS_CMD = 8'h09;
  localparam logic [7:0] READ_THIRD_STATUS_CMD = 8'h95;
  localparam logic [7:0] QUAD_COMMAND_MODE_ENTRY = 8'h38;
  localparam logic [7:0] QUAD_COMMAND_MODE_EXIT = 8'hff;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int WIP_BIT = 0;
  localparam int ERASE_SUSP_BIT = 2;
  localparam int PROG_SUSP_BIT = 3;
  localparam int PROG_FAIL_BIT = 5;
  localparam int ERASE_FAIL_BIT = 6;
  localparam int DUMMY_LSB = 4;
  localparam int DRIVE_LSB = 2;
  localparam logic [7:0] SECOND_STATUS_RESET = 8'h00;
  localparam logic [7:0] THIRD_STATUS_RESET = 8'h00;
  localparam logic [1:0] DUMMY_RESET = 2'b00;
  localparam logic [1:0] DRIVE_RESET = 2'b00;

  // ****************************************
  // Dummy byte codes and link timing counts
  // ****************************************
  localparam logic [2:0] DUMMY_BYTES_CODE0 = 3'd3;
  localparam logic [2:0] DUMMY_BYTES_CODE1 = 3'd2;
  localparam logic [2:0] DUMMY_BYTES_CODE2 = 3'd4;
  localparam logic [2:0] DUMMY_BYTES_CODE3 = 3'd5;
  localparam logic [2:0] QUAD_CLOCKS_PER_BYTE = 3'd2;
  localparam logic [2:0] SINGLE_LAST_CLOCK = 3'd7;
  localparam logic [2:0] QUAD_LAST_CLOCK = 3'd1;

  typedef enum logic [1:0] {
    FSR_SEL_NONE,
    FSR_SEL_SECOND,
    FSR_SEL_THIRD
  } fsr_sel_e;

  typedef enum logic [1:0] {
    FSR_LINK_OPCODE,
    FSR_LINK_SEND,
    FSR_LINK_IGNORE
  } fsr_link_e;

endpackage : fsr_pkg

// file: include/fsr_tx_if.sv
// Carrier between the link decoder and the falling-edge output shifter.
`timescale 1ns/100ps
`default_nettype none
interface fsr_tx_if;
  logic frame_rst;
  logic active;
  logic quad;
  logic [7:0] tx_byte;
  modport decoder (output frame_rst, output active, output quad, output tx_byte);
  modport shifter (input frame_rst, input active, input quad, input tx_byte);
endinterface : fsr_tx_if
`default_nettype wire

// file: rtl/fsr_shifter.sv
// Falling-edge output shifter that repeats the selected status byte on the data pins.
`timescale 1ns/100ps
`default_nettype none
module fsr_shifter (
  input wire logic i_sclk,
  fsr_tx_if.shifter tx,
  output logic [3:0] o_dq_out,
  output logic [3:0] o_dq_oe_n
);
  import fsr_pkg::*;

  logic [7:0] sh_q;
  logic [2:0] cnt_q;
  logic last;

  // Byte boundary: eight clocks single line, two clocks in quad mode.
  assign last = tx.quad ? (cnt_q == QUAD_LAST_CLOCK) : (cnt_q == SINGLE_LAST_CLOCK);

  // ****************************************
  // Shift register
  // ****************************************
  // Chip select high ends the frame at once, even with the clock stopped.
  always_ff @(negedge i_sclk or posedge tx.frame_rst) begin
    if (tx.frame_rst) begin
      sh_q <= 8'h00;
      cnt_q <= 3'd0;
    end else if (tx.active) begin
      if (cnt_q == 3'd0) begin
        sh_q <= tx.tx_byte;
      end else if (tx.quad) begin
        sh_q <= {sh_q[3:0], 4'h0};
      end else begin
        sh_q <= {sh_q[6:0], 1'b0};
      end
      cnt_q <= last ? 3'd0 : cnt_q + 3'd1;
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  // Single line answers on data line 1 only; quad mode drives all four.
  always_ff @(negedge i_sclk or posedge tx.frame_rst) begin
    if (tx.frame_rst) begin
      o_dq_oe_n <= 4'hf;
    end else if (tx.active) begin
      o_dq_oe_n <= tx.quad ? 4'h0 : 4'hd;
    end
  end

  // The enables gate these bits, so idle values never reach the wire.
  assign o_dq_out = tx.quad ? sh_q[7:4] : {2'b00, sh_q[7], 1'b0};

endmodule : fsr_shifter
`default_nettype wire

// file: rtl/fsr_top.sv
// Second and third flash status registers with their serial read-out path.
`timescale 1ns/100ps
`default_nettype none
module fsr_top (
  input wire logic i_mclk,
  input wire logic i_reset,
  // Serial link pins.
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic [3:0] i_dq_in,
  output logic [3:0] o_dq_out,
  output logic [3:0] o_dq_oe_n,
  // Events and levels from the internal write engine, on i_mclk.
  input wire logic i_write_busy,
  input wire logic i_erase_running,
  input wire logic i_program_running,
  input wire logic i_suspend,
  input wire logic i_resume,
  input wire logic i_program_fail,
  input wire logic i_program_denied,
  input wire logic i_erase_fail,
  input wire logic i_erase_denied,
  input wire logic i_fail_clear_cmd,
  // Volatile configuration load for the third register.
  input wire logic i_config_load,
  input wire logic [1:0] i_config_dummy,
  input wire logic [1:0] i_config_drive,
  // Status views for the rest of the device.
  output logic [7:0] o_second_status,
  output logic [7:0] o_third_status,
  output logic [2:0] o_dummy_bytes,
  output logic [3:0] o_dummy_quad_clocks,
  output logic [1:0] o_drive_strength,
  output logic o_quad_mode
);
  import fsr_pkg::*;

  // ****************************************
  // Core domain state
  // ****************************************
  logic wip_q;
  logic erase_susp_q;
  logic prog_susp_q;
  logic prog_fail_q;
  logic erase_fail_q;
  logic [1:0] dummy_q;
  logic [1:0] drive_q;
  logic [7:0] second_live;
  logic [7:0] third_live;

  // Crossing toward the link.
  logic [15:0] hold_q;
  logic req_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic pending;

  // Link domain state.
  logic frame_rst;
  logic req_s1_q;
  logic req_s2_q;
  logic ack_q;
  logic [15:0] copy_q;
  fsr_link_e link_q;
  fsr_sel_e sel_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] op_q;
  logic [7:0] op_next;
  logic op_last;
  logic op_done;
  logic quad_q;
  logic quad_s1_q;
  logic quad_s2_q;

  fsr_tx_if tx ();

  // ****************************************
  // Busy mirror
  // ****************************************
  // A register keeps the bit glitch free against the engine's own logic.
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      wip_q <= 1'b0;
    end else begin
      wip_q <= i_write_busy;
    end
  end

  // ****************************************
  // Suspend flags
  // ****************************************
  // A program may be suspended inside a suspended erase, so a resume undoes
  // the program suspension first. A suspend in the resume cycle wins.
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      erase_susp_q <= 1'b0;
      prog_susp_q <= 1'b0;
    end else begin
      if (i_suspend && i_program_running) begin
        prog_susp_q <= 1'b1;
      end else if (i_resume && prog_susp_q) begin
        prog_susp_q <= 1'b0;
      end
      if (i_suspend && i_erase_running && !i_program_running) begin
        erase_susp_q <= 1'b1;
      end else if (i_resume && !prog_susp_q && erase_susp_q) begin
        erase_susp_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Failure flags
  // ****************************************
  // The flags accumulate; only the fail clear command clears
  // them, and a failure in that same cycle still leaves the flag set.
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      prog_fail_q <= 1'b0;
      erase_fail_q <= 1'b0;
    end else begin
      if (i_program_fail || i_program_denied) begin
        prog_fail_q <= 1'b1;
      end else if (i_fail_clear_cmd) begin
        prog_fail_q <= 1'b0;
      end
      if (i_erase_fail || i_erase_denied) begin
        erase_fail_q <= 1'b1;
      end else if (i_fail_clear_cmd) begin
        erase_fail_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Third register fields
  // ****************************************
  // Volatile: the written settings are lost at every reset.
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      dummy_q <= DUMMY_RESET;
      drive_q <= DRIVE_RESET;
    end else if (i_config_load) begin
      dummy_q <= i_config_dummy;
      drive_q <= i_config_drive;
    end
  end

  // ****************************************
  // Register images
  // ****************************************
  // Reserved positions are forced to zero here, never stored.
  always_comb begin
    second_live = SECOND_STATUS_RESET;
    second_live[WIP_BIT] = wip_q;
    second_live[ERASE_SUSP_BIT] = erase_susp_q;
    second_live[PROG_SUSP_BIT] = prog_susp_q;
    second_live[PROG_FAIL_BIT] = prog_fail_q;
    second_live[ERASE_FAIL_BIT] = erase_fail_q;
    third_live = THIRD_STATUS_RESET;
    third_live[DUMMY_LSB+:2] = dummy_q;
    third_live[DRIVE_LSB+:2] = drive_q;
  end

  assign o_second_status = second_live;
  assign o_third_status = third_live;
  assign o_drive_strength = drive_q;

  // ****************************************
  // Dummy length decode
  // ****************************************
  // Quad reads spend two clocks on every dummy byte.
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_dummy_bytes <= DUMMY_BYTES_CODE0;
      o_dummy_quad_clocks <= 4'(DUMMY_BYTES_CODE0) * 4'(QUAD_CLOCKS_PER_BYTE);
    end else begin
      case (dummy_q)
        2'b00: begin
          o_dummy_bytes <= DUMMY_BYTES_CODE0;
          o_dummy_quad_clocks <= 4'(DUMMY_BYTES_CODE0) * 4'(QUAD_CLOCKS_PER_BYTE);
        end
        2'b01: begin
          o_dummy_bytes <= DUMMY_BYTES_CODE1;
          o_dummy_quad_clocks <= 4'(DUMMY_BYTES_CODE1) * 4'(QUAD_CLOCKS_PER_BYTE);
        end
        2'b10: begin
          o_dummy_bytes <= DUMMY_BYTES_CODE2;
          o_dummy_quad_clocks <= 4'(DUMMY_BYTES_CODE2) * 4'(QUAD_CLOCKS_PER_BYTE);
        end
        default: begin
          o_dummy_bytes <= DUMMY_BYTES_CODE3;
          o_dummy_quad_clocks <= 4'(DUMMY_BYTES_CODE3) * 4'(QUAD_CLOCKS_PER_BYTE);
        end
      endcase
    end
  end

  // ****************************************
  // Crossing: core side
  // ****************************************
  // Toggle handshake on a held word. The link clock stops between frames,
  // so an update may wait there; the held word stays put until acknowledged.
  assign pending = req_q ^ ack_s2_q;

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      hold_q <= {THIRD_STATUS_RESET, SECOND_STATUS_RESET};
      req_q <= 1'b0;
    end else if (!pending && (hold_q != {third_live, second_live})) begin
      hold_q <= {third_live, second_live};
      req_q <= ~req_q;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  // ****************************************
  // Crossing: link side
  // ****************************************
  always_ff @(posedge i_sclk or posedge i_reset) begin
    if (i_reset) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      ack_q <= 1'b0;
      copy_q <= {THIRD_STATUS_RESET, SECOND_STATUS_RESET};
    end else begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      if (req_s2_q != ack_q) begin
        copy_q <= hold_q;
        ack_q <= req_s2_q;
      end
    end
  end

  // ****************************************
  // Opcode receiver
  // ****************************************
  // Chip select high clears all frame state without needing a clock edge.
  assign frame_rst = i_reset | i_cs_n;
  assign op_next = quad_q ? {op_q[3:0], i_dq_in} : {op_q[6:0], i_dq_in[0]};
  assign op_last = quad_q ? (bit_cnt_q == QUAD_LAST_CLOCK) : (bit_cnt_q == SINGLE_LAST_CLOCK);
  assign op_done = (link_q == FSR_LINK_OPCODE) && op_last;

  always_ff @(posedge i_sclk or posedge frame_rst) begin
    if (frame_rst) begin
      link_q <= FSR_LINK_OPCODE;
      sel_q <= FSR_SEL_NONE;
      bit_cnt_q <= 3'd0;
      op_q <= 8'h00;
    end else begin
      case (link_q)
        FSR_LINK_OPCODE: begin
          op_q <= op_next;
          bit_cnt_q <= bit_cnt_q + 3'd1;
          if (op_last) begin
            if (op_next == READ_SECOND_STATUS_CMD) begin
              link_q <= FSR_LINK_SEND;
              sel_q <= FSR_SEL_SECOND;
            end else if (op_next == READ_THIRD_STATUS_CMD) begin
              link_q <= FSR_LINK_SEND;
              sel_q <= FSR_SEL_THIRD;
            end else begin
              link_q <= FSR_LINK_IGNORE;
            end
          end
        end
        // Stays here until chip select rises, so the byte keeps repeating.
        FSR_LINK_SEND: begin
          link_q <= FSR_LINK_SEND;
        end
        FSR_LINK_IGNORE: begin
          link_q <= FSR_LINK_IGNORE;
        end
        default: begin
          link_q <= FSR_LINK_IGNORE;
        end
      endcase
    end
  end

  // ****************************************
  // Quad command mode
  // ****************************************
  // Persists across frames; only a reset or the exit code leaves it.
  always_ff @(posedge i_sclk or posedge i_reset) begin
    if (i_reset) begin
      quad_q <= 1'b0;
    end else if (op_done && (op_next == QUAD_COMMAND_MODE_ENTRY)) begin
      quad_q <= 1'b1;
    end else if (op_done && (op_next == QUAD_COMMAND_MODE_EXIT)) begin
      quad_q <= 1'b0;
    end
  end

  // Level crossing of the mode flag for the rest of the device.
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      quad_s1_q <= 1'b0;
      quad_s2_q <= 1'b0;
    end else begin
      quad_s1_q <= quad_q;
      quad_s2_q <= quad_s1_q;
    end
  end

  assign o_quad_mode = quad_s2_q;

  // ****************************************
  // Output shifter
  // ****************************************
  // The shifter reloads at each byte boundary, so polling shows updates.
  assign tx.frame_rst = frame_rst;
  assign tx.active = (link_q == FSR_LINK_SEND);
  assign tx.quad = quad_q;
  assign tx.tx_byte = (sel_q == FSR_SEL_THIRD) ? copy_q[15:8] : copy_q[7:0];

  fsr_shifter u_shifter (
    .i_sclk(i_sclk),
    .tx(tx.shifter),
    .o_dq_out(o_dq_out),
    .o_dq_oe_n(o_dq_oe_n)
  );

endmodule : fsr_top
`default_nettype wire

// file: tb/fsr_host_model.sv
// Behavioural host controller that runs serial status read frames.
`timescale 1ns/100ps
`default_nettype none
// ********
// Host
// ********
module fsr_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic [3:0] o_dq,
  input wire logic [3:0] i_dq_out,
  input wire logic [3:0] i_dq_oe_n
);
  logic [3:0] h_en;
  logic [3:0] h_val;
  // A line nobody drives shows the inverse of the last host value, so stale data fails.
  assign o_dq = (~i_dq_oe_n & i_dq_out) | (i_dq_oe_n & ~(h_en ^ h_val) & 4'hf);
  // The link clock stands still outside frames.
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    h_en = 4'h0;
    h_val = 4'h0;
  end
  // One frame: opcode, then nb bytes read back; returns the last byte and enables seen.
  task automatic xfer(input logic [7:0] op, input logic quad, input int nb,
                      output logic [7:0] last, output logic [3:0] oe);
    int n;
    n = quad ? 2 : 8;
    last = 8'h00;
    oe = 4'hf;
    o_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      h_en = quad ? 4'hf : 4'h1;
      h_val = quad ? (i == 0 ? op[7:4] : op[3:0]) : {3'h0, op[7 - i]};
      #7.5 o_sclk = 1'b1;
      #7.5 o_sclk = 1'b0;
    end
    h_en = 4'h0;
    for (int i = 0; i < nb * n; i++) begin
      #7.5 last = quad ? {last[3:0], o_dq} : {last[6:0], o_dq[1]};
      oe = i_dq_oe_n;
      o_sclk = 1'b1;
      #7.5 o_sclk = 1'b0;
    end
    #5 o_cs_n = 1'b1;
    #10;
  endtask : xfer
endmodule : fsr_host_model
`default_nettype wire

// file: tb/fsr_top_props.sv
// Concurrent checks on the ports of the flash status block.
`timescale 1ns/100ps
`default_nettype none
// ********
// Checker
// ********
module fsr_top_props (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_write_busy,
  input wire logic i_erase_running,
  input wire logic i_program_running,
  input wire logic i_suspend,
  input wire logic i_resume,
  input wire logic i_program_fail,
  input wire logic i_program_denied,
  input wire logic i_erase_fail,
  input wire logic i_erase_denied,
  input wire logic i_fail_clear_cmd,
  input wire logic [7:0] o_second_status,
  input wire logic [7:0] o_third_status,
  input wire logic [2:0] o_dummy_bytes
);
  import fsr_pkg::*;
  // Everything here lives on the core clock, so clocking and reset are given once.
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);
  property p_busy; 1'b1 |=> o_second_status[0] == $past(i_write_busy); endproperty
  a_busy: assert property (p_busy) else $error("busy bit wrong");
  property p_resv; {o_second_status[7], o_second_status[4], o_second_status[1],
    o_third_status[7:6], o_third_status[1:0]} == 7'h00; endproperty
  a_resv: assert property (p_resv) else $error("reserved bit set");
  property p_pfail; i_program_fail || i_program_denied |=> o_second_status[5]; endproperty
  a_pfail: assert property (p_pfail) else $error("program fail missed");
  property p_efail; i_erase_fail || i_erase_denied |=> o_second_status[6]; endproperty
  a_efail: assert property (p_efail) else $error("erase fail missed");
  property p_clear; i_fail_clear_cmd && !i_program_fail && !i_program_denied
    |=> !o_second_status[5]; endproperty
  a_clear: assert property (p_clear) else $error("fail flag not cleared");
  property p_stick; o_second_status[6] && !i_fail_clear_cmd |=> o_second_status[6]; endproperty
  a_stick: assert property (p_stick) else $error("fail flag dropped");
  property p_esusp; i_suspend && i_erase_running && !i_program_running
    |=> o_second_status[2]; endproperty
  a_esusp: assert property (p_esusp) else $error("erase suspend missed");
  property p_psusp; i_suspend && i_program_running |=> o_second_status[3]; endproperty
  a_psusp: assert property (p_psusp) else $error("program suspend missed");
  property p_resume; i_resume && !i_suspend && o_second_status[3]
    |=> !o_second_status[3] && $stable(o_second_status[2]); endproperty
  a_resume: assert property (p_resume) else $error("resume wrong");
  property p_dummy; $stable(o_third_status[5:4]) |-> o_dummy_bytes ==
    (o_third_status[5] ? (o_third_status[4] ? 3'h5 : 3'h4)
    : (o_third_status[4] ? 3'h2 : 3'h3)); endproperty
  a_dummy: assert property (p_dummy) else $error("dummy count wrong");
endmodule : fsr_top_props
bind fsr_top fsr_top_props props_u (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_write_busy(i_write_busy),
  .i_erase_running(i_erase_running), .i_program_running(i_program_running),
  .i_suspend(i_suspend), .i_resume(i_resume), .i_program_fail(i_program_fail),
  .i_program_denied(i_program_denied), .i_erase_fail(i_erase_fail),
  .i_erase_denied(i_erase_denied), .i_fail_clear_cmd(i_fail_clear_cmd),
  .o_second_status(o_second_status), .o_third_status(o_third_status),
  .o_dummy_bytes(o_dummy_bytes)
);
`default_nettype wire

// file: tb/fsr_top_test.sv
// Self-checking bench for the flash status block.
`timescale 1ns/100ps
`default_nettype none
`define check_eq(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("FAIL %0t got %h want %h", $time, got, exp); \
    end \
  end
// ********
// Bench
// ********
module fsr_top_test;
  import fsr_pkg::*;
  logic i_mclk = 1'b0;
  logic i_reset, i_write_busy, i_erase_running, i_program_running;
  logic [1:0] i_config_dummy, i_config_drive;
  logic [7:0] ev_q, rd;
  logic [3:0] oe;
  wire i_sclk, i_cs_n, o_quad_mode;
  wire [3:0] i_dq_in, o_dq_out, o_dq_oe_n, o_dummy_quad_clocks;
  wire [7:0] o_second_status, o_third_status;
  wire [2:0] o_dummy_bytes;
  wire [1:0] o_drive_strength;
  int bad_count, num_checks, cyc;
  fsr_top dut_u (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
    .i_dq_in(i_dq_in), .o_dq_out(o_dq_out), .o_dq_oe_n(o_dq_oe_n),
    .i_write_busy(i_write_busy), .i_erase_running(i_erase_running),
    .i_program_running(i_program_running), .i_suspend(ev_q[0]), .i_resume(ev_q[1]),
    .i_program_fail(ev_q[2]), .i_program_denied(ev_q[3]), .i_erase_fail(ev_q[4]),
    .i_erase_denied(ev_q[5]), .i_fail_clear_cmd(ev_q[6]), .i_config_load(ev_q[7]),
    .i_config_dummy(i_config_dummy), .i_config_drive(i_config_drive),
    .o_second_status(o_second_status), .o_third_status(o_third_status),
    .o_dummy_bytes(o_dummy_bytes), .o_dummy_quad_clocks(o_dummy_quad_clocks),
    .o_drive_strength(o_drive_strength), .o_quad_mode(o_quad_mode)
  );
  fsr_host_model host_u (
    .o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_dq(i_dq_in), .i_dq_out(o_dq_out),
    .i_dq_oe_n(o_dq_oe_n)
  );
  // Core clock, and a watchdog far beyond the few hundred cycles the run needs.
  always #5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 8000) begin
      bad_count++;
      results();
    end
  end
  task tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : tick
  // Pulses are dropped and an edge passes, so pulses from two calls never share a clock cycle.
  task ev(input logic [7:0] m);
    ev_q = m;
    tick(1);
    ev_q = 8'h00;
    tick(1);
  endtask : ev
  task link(input logic [7:0] op, input logic quad, input int nb);
    host_u.xfer(op, quad, nb, rd, oe);
    `check_eq(o_dq_oe_n, 4'hf)
    tick(1);
  endtask : link
  task results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  task t_reset;
    i_reset = 1'b1;
    tick(10);
    i_reset = 1'b0;
    `check_eq({o_second_status, o_third_status}, {SECOND_STATUS_RESET, THIRD_STATUS_RESET})
    `check_eq({o_dummy_bytes, o_dummy_quad_clocks, o_quad_mode}, 8'h6c)
    $display("test reset done");
  endtask : t_reset
  task t_busy;
    i_write_busy = 1'b1;
    tick(2);
    link(READ_SECOND_STATUS_CMD, 1'b0, 2);
    `check_eq({rd, oe}, 12'h01d)
    i_write_busy = 1'b0;
    tick(2);
    link(READ_SECOND_STATUS_CMD, 1'b0, 1);
    `check_eq(rd[0], 1'b0)
    link(8'h03, 1'b0, 1);
    `check_eq(oe, 4'hf)
    $display("test busy done");
  endtask : t_busy
  task t_susp;
    i_erase_running = 1'b1;
    ev(8'h01);
    `check_eq(o_second_status, 8'h04)
    i_erase_running = 1'b0;
    i_program_running = 1'b1;
    ev(8'h01);
    i_program_running = 1'b0;
    link(READ_SECOND_STATUS_CMD, 1'b0, 1);
    `check_eq(rd, 8'h0c)
    ev(8'h02);
    `check_eq(o_second_status, 8'h04)
    ev(8'h02);
    ev(8'h02);
    `check_eq(o_second_status, 8'h00)
    $display("test suspend done");
  endtask : t_susp
  task automatic t_fail;
    logic [7:0] m [6] = '{8'h04, 8'h20, 8'h50, 8'h08, 8'h10, 8'h40};
    logic [7:0] e [6] = '{8'h20, 8'h60, 8'h40, 8'h60, 8'h60, 8'h00};
    for (int i = 0; i < 6; i++) begin
      ev(m[i]);
      `check_eq(o_second_status, e[i])
      if (i == 4) begin
        link(READ_SECOND_STATUS_CMD, 1'b0, 3);
        `check_eq(rd, 8'h60)
        `check_eq(rd & 8'h6d, 8'h60)
      end
    end
    $display("test fail done");
  endtask : t_fail
  task automatic t_cfg;
    logic [2:0] nb [4] = '{3'h3, 3'h2, 3'h4, 3'h5};
    for (int k = 0; k < 4; k++) begin
      i_config_dummy = k[1:0];
      i_config_drive = ~k[1:0];
      ev(8'h80);
      `check_eq({o_dummy_bytes, o_dummy_quad_clocks}, {nb[k], nb[k], 1'b0})
      `check_eq(o_drive_strength, ~k[1:0])
      link(READ_THIRD_STATUS_CMD, 1'b0, 2);
      `check_eq(rd, {2'b00, k[1:0], ~k[1:0], 2'b00})
    end
    $display("test config done");
  endtask : t_cfg
  task t_quad;
    link(QUAD_COMMAND_MODE_ENTRY, 1'b0, 0);
    tick(4);
    `check_eq(o_quad_mode, 1'b1)
    i_write_busy = 1'b1;
    link(READ_SECOND_STATUS_CMD, 1'b1, 2);
    `check_eq({rd, oe}, 12'h010)
    link(READ_THIRD_STATUS_CMD, 1'b1, 3);
    `check_eq(rd, 8'h30)
    i_write_busy = 1'b0;
    link(QUAD_COMMAND_MODE_EXIT, 1'b1, 0);
    tick(4);
    `check_eq(o_quad_mode, 1'b0)
    $display("test quad done");
  endtask : t_quad
  // Main sequence; the closing reset lands on a non-default state.
  initial begin
    i_reset = 1'b1;
    {i_write_busy, i_erase_running, i_program_running} = 3'h0;
    {i_config_dummy, i_config_drive, ev_q} = 12'h000;
    tick(0);
    t_reset();
    t_busy();
    t_susp();
    t_fail();
    t_cfg();
    t_quad();
    t_reset();
    results();
  end
endmodule : fsr_top_test
`default_nettype wire
